// ### rtl/drive_fault_protect_config.sv
// Fault handling and protection settings of a motor drive, APB slave
module drive_fault_protect_config
    import drive_protect_pkg::*;
#(
    parameter longint DRIVE_TRIP_CYC  = DRIVE_TRIP_CYCLES,
    parameter longint MOTOR_STD_CYC   = MOTOR_STD_CYCLES,
    parameter longint MOTOR_SHORT_CYC = MOTOR_SHORT_CYCLES,
    parameter bit     LARGE_RATING    = 1'b1
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // External contact and sequence pins
    input  wire logic        extFaultContact,
    input  wire logic        faultResetIn,
    input  wire logic        forwardRunInput,
    input  wire logic        reverseRunInput,
    input  wire logic        outputBlocked,
    // Measured output current, percent of rating
    input  wire logic [7:0]  outputCurrentPct,
    // Fault outputs
    output logic             faultContactOut,
    output logic [7:0]       faultCode,
    output logic             stopRampFirst,
    output logic             stopRampSecond,
    output logic             stopCoast,
    output logic             minorFault,
    output logic             motorThermalTrip,
    output logic             driveThermalTrip,
    // Active settings
    output logic [1:0]       activeMethod,
    output logic             motorCurveConstTorque,
    // Interrupt
    output logic             irq
);

    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    logic contactRaw;
    logic faultInSync;
    logic resetSync;
    logic fwdSync;
    logic revSync;

    sync2 uFaultSync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .dIn     (contactRaw),
        .dOut    (faultInSync)
    );

    sync2 uResetSync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .dIn     (faultResetIn),
        .dOut    (resetSync)
    );

    sync2 uFwdSync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .dIn     (forwardRunInput),
        .dOut    (fwdSync)
    );

    sync2 uRevSync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .dIn     (reverseRunInput),
        .dOut    (revSync)
    );

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [3:0]           extFaultSetup_reg;
    logic [1:0]           controlMethodSelect_reg;
    logic [3:0]           thermalSetup_reg;
    logic [1:0]           activeMethod_reg;
    logic                 faultLatch_reg;
    logic [IRQ_WIDTH-1:0] irqStatus_reg;
    logic [IRQ_WIDTH-1:0] irqEnable_reg;
    logic                 powerUpDone_reg;
    logic                 resetPrev_reg;
    logic [31:0]          prdata_reg;

    // Polarity correction ahead of the synchroniser, so only a sync'd level is used
    assign contactRaw = extFaultContact ^ extFaultSetup_reg[EF_POLARITY_BIT];

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire logic access   = psel && penable;
    wire logic wrAccess = access && pwrite;
    wire logic rdAccess = access && !pwrite;
    wire logic hitSetup   = (paddr == EXT_FAULT_SETUP_OFS);
    wire logic hitMethod  = (paddr == CTRL_METHOD_SEL_OFS);
    wire logic hitThermal = (paddr == THERMAL_SETUP_OFS);
    wire logic hitActive  = (paddr == ACTIVE_METHOD_OFS);
    wire logic hitStatus  = (paddr == FAULT_STATUS_OFS);
    wire logic hitIrqSt   = (paddr == IRQ_STATUS_OFS);
    wire logic hitIrqEn   = (paddr == IRQ_ENABLE_OFS);
    wire logic hitIrqClr  = (paddr == IRQ_CLEAR_OFS);
    wire logic hitCtl     = (paddr == CONTROL_OFS);
    wire logic mapped = hitSetup | hitMethod | hitThermal | hitActive | hitStatus
                      | hitIrqSt | hitIrqEn | hitIrqClr | hitCtl;

    // Control register write: bit 0 fault reset, bit 1 power-up event
    wire logic swFaultReset = wrAccess && hitCtl && pwdata[CTL_RESET_BIT];
    wire logic swPowerUp    = wrAccess && hitCtl && pwdata[CTL_POWERUP_BIT];

    // ----------------------------------------
    // Setting registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            extFaultSetup_reg       <= EXT_FAULT_SETUP_RST;
            controlMethodSelect_reg <= CTRL_METHOD_SEL_RST;
            thermalSetup_reg        <= THERMAL_SETUP_RST;
            irqEnable_reg           <= '0;
        end else if (wrAccess) begin
            if (hitSetup) begin
                extFaultSetup_reg <= pwdata[3:0];
            end
            if (hitMethod) begin
                controlMethodSelect_reg <= pwdata[1:0];
            end
            if (hitThermal) begin
                thermalSetup_reg <= pwdata[3:0];
            end
            if (hitIrqEn) begin
                irqEnable_reg <= pwdata[IRQ_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------
    // Control method adoption
    // ----------------------------------------
    // Reset stands for power removal; adoption occurs on the first clock after power-up
    // or on an explicit power-up write. Plain register writes never touch it.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            powerUpDone_reg  <= 1'b0;
            activeMethod_reg <= PLAIN_VF_MODE;
        end else begin
            powerUpDone_reg <= 1'b1;
            if (!powerUpDone_reg || swPowerUp) begin
                activeMethod_reg <= controlMethodSelect_reg;
            end
        end
    end

    // ----------------------------------------
    // External fault qualification and latch
    // ----------------------------------------
    // Ride-through relies on the run inputs staying high across a supply dip
    wire logic running       = (fwdSync || revSync) && !outputBlocked;
    wire logic faultAccepted = faultInSync
                             && (!extFaultSetup_reg[EF_RUN_ONLY_BIT] || running);
    wire logic resetRise     = resetSync && !resetPrev_reg;
    wire logic faultClear    = resetRise || swFaultReset;
    wire fault_action_t action = fault_action_t'(extFaultSetup_reg[EF_ACTION_LSB +: 2]);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            faultLatch_reg <= 1'b0;
            resetPrev_reg  <= 1'b0;
        end else begin
            resetPrev_reg <= resetSync;
            // Set wins when a new fault meets a reset in the same cycle
            if (faultAccepted) begin
                faultLatch_reg <= 1'b1;
            end else if (faultClear) begin
                faultLatch_reg <= 1'b0;
            end
        end
    end

    // Contact and code follow the latch directly, no added delay
    assign faultContactOut = faultLatch_reg;
    assign faultCode       = faultLatch_reg ? TERMINAL_THREE_FAULT_CODE : 8'h00;
    assign stopRampFirst   = faultLatch_reg && (action == ACT_RAMP_FIRST);
    assign stopCoast       = faultLatch_reg && (action == ACT_COAST);
    assign stopRampSecond  = faultLatch_reg && (action == ACT_RAMP_SECOND);
    assign minorFault      = faultLatch_reg && (action == ACT_CONTINUE);

    // ----------------------------------------
    // Thermal overload
    // ----------------------------------------
    wire logic motorEnable = !thermalSetup_reg[TH_MOTOR_DIS_BIT];
    // Constant-torque curve keeps full protection at low speed; only flagged out here
    assign motorCurveConstTorque = thermalSetup_reg[TH_CURVE_BIT];
    wire logic [39:0] motorLimit = thermalSetup_reg[TH_SHORT_TC_BIT]
                                 ? 40'(MOTOR_SHORT_CYC) : 40'(MOTOR_STD_CYC);
    wire logic lightDuty = LARGE_RATING && thermalSetup_reg[TH_DRIVE_CHAR_BIT];
    wire logic [7:0] driveStart = lightDuty ? DRIVE_START_LIGHT : DRIVE_START_NORMAL;
    wire logic [7:0] driveTrip  = lightDuty ? DRIVE_TRIP_LIGHT : DRIVE_TRIP_NORMAL;
    // Accumulation is armed above the start level; the trip timer runs at the trip level
    wire logic driveAccum = outputCurrentPct > driveStart;
    wire logic driveOver  = driveAccum && (outputCurrentPct >= driveTrip);

    overload_timer #(
        .CNT_W (40)
    ) uMotorTimer (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .enable    (motorEnable),
        .overLevel (outputCurrentPct > MOTOR_START_PCT),
        .limit     (motorLimit),
        .clearTrip (faultClear),
        .trip      (motorThermalTrip)
    );

    overload_timer #(
        .CNT_W (40)
    ) uDriveTimer (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .enable    (1'b1),
        .overLevel (driveOver),
        .limit     (40'(DRIVE_TRIP_CYC)),
        .clearTrip (faultClear),
        .trip      (driveThermalTrip)
    );

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    logic [IRQ_WIDTH-1:0] irqEvents;
    logic [IRQ_WIDTH-1:0] irqClear;
    assign irqEvents = {driveThermalTrip, motorThermalTrip, faultAccepted};
    assign irqClear  = (wrAccess && hitIrqClr) ? pwdata[IRQ_WIDTH-1:0] : '0;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqStatus_reg <= '0;
        end else begin
            irqStatus_reg <= irqEvents | (irqStatus_reg & ~irqClear);
        end
    end

    assign irq = |(irqStatus_reg & irqEnable_reg);

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [31:0] readMux;
    always_comb begin
        readMux = 32'h0000_0000;
        if (hitSetup) begin
            readMux = {28'h0, extFaultSetup_reg};
        end else if (hitMethod) begin
            readMux = {30'h0, controlMethodSelect_reg};
        end else if (hitThermal) begin
            readMux = {28'h0, thermalSetup_reg};
        end else if (hitActive) begin
            readMux = {30'h0, activeMethod_reg};
        end else if (hitStatus) begin
            readMux = {16'h0, faultCode, 4'h0, driveThermalTrip,
                       motorThermalTrip, running, faultLatch_reg};
        end else if (hitIrqSt) begin
            readMux = {29'h0, irqStatus_reg};
        end else if (hitIrqEn) begin
            readMux = {29'h0, irqEnable_reg};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= readMux;
        end
    end

    assign prdata       = prdata_reg;
    assign pready       = 1'b1;
    assign pslverr      = access && !mapped;
    assign activeMethod = activeMethod_reg;

endmodule

// ### rtl/drive_protect_pkg.sv
// Shared constants for the drive fault protection and configuration block
package drive_protect_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] EXT_FAULT_SETUP_OFS   = 8'h00;
    localparam logic [7:0] CTRL_METHOD_SEL_OFS   = 8'h04;
    localparam logic [7:0] THERMAL_SETUP_OFS     = 8'h08;
    localparam logic [7:0] ACTIVE_METHOD_OFS     = 8'h0C;
    localparam logic [7:0] FAULT_STATUS_OFS      = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFS        = 8'h14;
    localparam logic [7:0] IRQ_ENABLE_OFS        = 8'h18;
    localparam logic [7:0] IRQ_CLEAR_OFS         = 8'h1C;
    localparam logic [7:0] CONTROL_OFS           = 8'h20;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [3:0] EXT_FAULT_SETUP_RST   = 4'h4;
    localparam logic [1:0] CTRL_METHOD_SEL_RST   = 2'h0;
    localparam logic [3:0] THERMAL_SETUP_RST     = 4'h0;

    // ----------------------------------------
    // Field positions (digit n is bit n-1)
    // ----------------------------------------
    localparam int EF_POLARITY_BIT   = 0;
    localparam int EF_RUN_ONLY_BIT   = 1;
    localparam int EF_ACTION_LSB     = 2;
    localparam int TH_MOTOR_DIS_BIT  = 0;
    localparam int TH_CURVE_BIT      = 1;
    localparam int TH_SHORT_TC_BIT   = 2;
    localparam int TH_DRIVE_CHAR_BIT = 3;
    localparam int CTL_RESET_BIT     = 0;
    localparam int CTL_POWERUP_BIT   = 1;

    // Interrupt status bit positions
    localparam int IRQ_EXT_FAULT     = 0;
    localparam int IRQ_MOTOR_TRIP    = 1;
    localparam int IRQ_DRIVE_TRIP    = 2;
    localparam int IRQ_WIDTH         = 3;

    // ----------------------------------------
    // Fault actions and control methods
    // ----------------------------------------
    typedef enum logic [1:0] {
        ACT_RAMP_FIRST  = 2'h0,
        ACT_COAST       = 2'h1,
        ACT_RAMP_SECOND = 2'h2,
        ACT_CONTINUE    = 2'h3
    } fault_action_t;

    typedef enum logic [1:0] {
        PLAIN_VF_MODE          = 2'h0,
        SENSORLESS_VECTOR_MODE = 2'h1,
        PID_SAVING_MODE        = 2'h2,
        ENCODER_LOOP_MODE      = 2'h3
    } control_method_t;

    localparam logic [7:0] TERMINAL_THREE_FAULT_CODE = 8'h03;

    // ----------------------------------------
    // Overload thresholds, percent of rated current
    // ----------------------------------------
    localparam logic [7:0] DRIVE_START_NORMAL = 8'd103;
    localparam logic [7:0] DRIVE_TRIP_NORMAL  = 8'd150;
    localparam logic [7:0] DRIVE_START_LIGHT  = 8'd113;
    localparam logic [7:0] DRIVE_TRIP_LIGHT   = 8'd123;
    localparam logic [7:0] MOTOR_START_PCT    = 8'd100;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam longint CLK_HZ            = 200000000;
    localparam longint DRIVE_TRIP_SEC    = 60;
    localparam longint MOTOR_TC_STD_MIN  = 8;
    localparam longint MOTOR_TC_SHORT_MIN = 5;
    localparam longint DRIVE_TRIP_CYCLES = DRIVE_TRIP_SEC * CLK_HZ;
    localparam longint MOTOR_STD_CYCLES  = MOTOR_TC_STD_MIN * 60 * CLK_HZ;
    localparam longint MOTOR_SHORT_CYCLES = MOTOR_TC_SHORT_MIN * 60 * CLK_HZ;

endpackage

// ### rtl/overload_timer.sv
// Persistence timer: counts while over threshold, trips at the limit
module overload_timer
    import drive_protect_pkg::*;
#(
    parameter int CNT_W = 40
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Control
    input  wire logic             enable,
    input  wire logic             overLevel,
    input  wire logic [CNT_W-1:0] limit,
    input  wire logic             clearTrip,
    // Result
    output logic                  trip
);

    logic [CNT_W-1:0] count_reg;
    logic             trip_reg;
    wire  logic       atLimit = (count_reg >= limit);
    wire  logic       counting = enable && overLevel;

    // Count leaks down when below threshold, a simple thermal-like model
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (!enable) begin
            count_reg <= '0;
        end else if (counting && !atLimit) begin
            count_reg <= count_reg + 1'b1;
        end else if (!counting && count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trip_reg <= 1'b0;
        end else if (counting && atLimit) begin
            trip_reg <= 1'b1;
        end else if (clearTrip) begin
            trip_reg <= 1'b0;
        end
    end

    assign trip = trip_reg;

endmodule

// ### rtl/sync2.sv
// Two flip-flop synchroniser for a single level
module sync2 (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Data
    input  wire logic dIn,
    output logic      dOut
);

    logic stage1_reg;
    logic stage2_reg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= dIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign dOut = stage2_reg;

endmodule

// ### verification/drive_fault_protect_config_bench.sv
// Self-checking bench of the drive fault protection block
module drive_fault_protect_config_bench import drive_protect_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DT = 100;
    localparam int MS = 120;
    logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, outputCurrentPct = 8'h00, faultCode;
    logic [31:0] pwdata = 32'h0, prdata, rd, rs = 32'hE7C1039C;
    logic        outputBlocked = 1'b0, faultOn = 1'b0, ncContact = 1'b0, runOn = 1'b0;
    logic        revSel = 1'b0, resetOn = 1'b0, pready, pslverr, irq, extFaultContact;
    logic        faultResetIn, forwardRunInput, reverseRunInput, faultContactOut;
    logic        stopRampFirst, stopRampSecond, stopCoast, minorFault, motorThermalTrip;
    logic        driveThermalTrip, motorCurveConstTorque;
    logic [1:0]  activeMethod;
    logic [7:0]  ofsTab [4] = '{8'h00, 8'h04, 8'h08, 8'h24};
    logic [31:0] rstTab [4] = '{32'h4, 32'h0, 32'h0, 32'h0};
    int          errCount = 0, compares = 0, mm;

    always #2.5 clk_sys = ~clk_sys;

    drive_fault_protect_config #(.DRIVE_TRIP_CYC(DT), .MOTOR_STD_CYC(200), .MOTOR_SHORT_CYC(MS))
        drive_fault_protect_config_i (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .extFaultContact, .faultResetIn, .forwardRunInput,
        .reverseRunInput, .outputBlocked, .outputCurrentPct, .faultContactOut, .faultCode,
        .stopRampFirst, .stopRampSecond, .stopCoast, .minorFault, .motorThermalTrip,
        .driveThermalTrip, .activeMethod, .motorCurveConstTorque, .irq);
    drive_side_model drive_side_model_i (.clk_sys, .faultOn, .ncContact, .runOn, .revSel,
        .resetOn, .extFaultContact, .forwardRunInput, .reverseRunInput, .faultResetIn);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic wrapUp();
        $display("compares %0d mismatches %0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic waitFor(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        chk("wait", s, v);
        if (s !== v) wrapUp();
    endtask
    // Zero wait states today, but the bound keeps a stuck slave from hanging
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", pready, 1'b1);
        if (pready !== 1'b1) wrapUp();
        @(posedge clk_sys);
    endtask
    task automatic clearFault();
        resetOn <= 1'b1;
        cyc(3);
        resetOn <= 1'b0;
        cyc(8);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        cyc(6);
        rst <= 1'b0;
        apb(1'b1, 8'h24, rs);
        foreach (ofsTab[i]) begin
            apb(1'b0, ofsTab[i], 32'h0);
            chk("reset value", rd, rstTab[i]);
        end
        runOn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rs = xs(rs);
            outputBlocked <= 1'b1;
            revSel <= rs[1];
            ncContact <= i[0];
            apb(1'b1, EXT_FAULT_SETUP_OFS, {rs[31:4], i[2:1], rs[0], i[0]});
            cyc(4);
            clearFault();
            faultOn <= 1'b1;
            cyc(10);
            chk("blocked", faultContactOut, !rs[0]);
            outputBlocked <= 1'b0;
            waitFor(faultContactOut, 1'b1, 12);
            chk("code", faultCode, TERMINAL_THREE_FAULT_CODE);
            chk("act", {minorFault, stopRampSecond, stopCoast, stopRampFirst}, 1 << i[2:1]);
            faultOn <= 1'b0;
            cyc(10);
            chk("held", faultContactOut, 1'b1);
            clearFault();
            chk("cleared", faultContactOut, 1'b0);
        end
        apb(1'b1, IRQ_ENABLE_OFS, 32'h0);
        apb(1'b1, IRQ_CLEAR_OFS, 32'h7);
        faultOn <= 1'b1;
        waitFor(faultContactOut, 1'b1, 12);
        faultOn <= 1'b0;
        cyc(2);
        chk("irq masked", irq, 1'b0);
        apb(1'b0, IRQ_STATUS_OFS, 32'h0);
        chk("irq status", rd, 32'h1);
        apb(1'b1, IRQ_ENABLE_OFS, 32'h1);
        cyc(1);
        chk("irq raised", irq, 1'b1);
        clearFault();
        apb(1'b1, IRQ_CLEAR_OFS, 32'h1);
        cyc(1);
        chk("irq cleared", irq, 1'b0);
        for (int m = 0; m < 4; m++) begin
            rs = xs(rs);
            mm = (m + 1) % 4;
            apb(1'b1, CTRL_METHOD_SEL_OFS, {rs[31:2], mm[1:0]});
            apb(1'b0, CTRL_METHOD_SEL_OFS, 32'h0);
            chk("method", rd, mm);
            chk("method held", activeMethod, m);
            apb(1'b1, CONTROL_OFS, 32'h2);
            cyc(2);
            chk("method adopted", activeMethod, mm);
        end
        apb(1'b1, THERMAL_SETUP_OFS, 32'h3);
        cyc(1);
        chk("curve", motorCurveConstTorque, 1'b1);
        outputCurrentPct <= 8'h82;
        cyc(150);
        chk("drive below", driveThermalTrip, 1'b0);
        apb(1'b1, THERMAL_SETUP_OFS, 32'h9);
        cyc(DT - 10);
        chk("light early", driveThermalTrip, 1'b0);
        waitFor(driveThermalTrip, 1'b1, 30);
        outputCurrentPct <= 8'h00;
        clearFault();
        cyc(300);
        apb(1'b1, THERMAL_SETUP_OFS, 32'h1);
        cyc(1);
        chk("curve", motorCurveConstTorque, 1'b0);
        outputCurrentPct <= 8'h96;
        cyc(DT - 10);
        chk("normal early", driveThermalTrip, 1'b0);
        waitFor(driveThermalTrip, 1'b1, 30);
        cyc(8);
        chk("motor off", motorThermalTrip, 1'b0);
        outputCurrentPct <= 8'h00;
        clearFault();
        cyc(300);
        apb(1'b1, THERMAL_SETUP_OFS, 32'h4);
        outputCurrentPct <= 8'h65;
        cyc(MS - 20);
        chk("motor early", motorThermalTrip, 1'b0);
        waitFor(motorThermalTrip, 1'b1, 60);
        chk("drive at 101", driveThermalTrip, 1'b0);
        wrapUp();
    end
endmodule

bind drive_fault_protect_config drive_protect_properties #(.DRIVE_TRIP_CYC(DRIVE_TRIP_CYC))
    drive_protect_properties_i (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pslverr, .faultResetIn, .outputCurrentPct, .faultContactOut, .faultCode,
    .stopRampFirst, .stopRampSecond, .stopCoast, .minorFault, .driveThermalTrip,
    .activeMethod, .motorCurveConstTorque);

// ### verification/drive_protect_properties.sv
// Port-level checks of the drive fault protection block
module drive_protect_properties
    import drive_protect_pkg::*;
#(
    parameter longint DRIVE_TRIP_CYC = 100
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Pins and outputs
    input wire logic        faultResetIn,
    input wire logic [7:0]  outputCurrentPct,
    input wire logic        faultContactOut,
    input wire logic [7:0]  faultCode,
    input wire logic        stopRampFirst,
    input wire logic        stopRampSecond,
    input wire logic        stopCoast,
    input wire logic        minorFault,
    input wire logic        driveThermalTrip,
    input wire logic [1:0]  activeMethod,
    input wire logic        motorCurveConstTorque
);
    timeunit 1ns;
    timeprecision 1ps;
    wire         acc    = psel && penable;
    wire         ctlWr  = acc && pwrite && paddr == CONTROL_OFS;
    wire         pwrWr  = ctlWr && pwdata[CTL_POWERUP_BIT];
    wire         thWr   = psel && pwrite && paddr == THERMAL_SETUP_OFS;
    wire         mapped = paddr <= CONTROL_OFS && paddr[1:0] == 2'h0;
    logic [15:0] hiCnt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Restarts when a trip is cleared, so a cleared trip never looks overdue
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hiCnt <= 16'h0000;
        end else if (outputCurrentPct < 8'h96 || $fell(driveThermalTrip)) begin
            hiCnt <= 16'h0000;
        end else if (hiCnt != 16'hFFFF) begin
            hiCnt <= hiCnt + 16'h0001;
        end
    end

    property p_faultCode;
        faultCode == (faultContactOut ? TERMINAL_THREE_FAULT_CODE : 8'h00);
    endproperty
    property p_stopAction;
        faultContactOut ? $onehot({minorFault, stopRampSecond, stopCoast, stopRampFirst})
                        : !(minorFault || stopRampSecond || stopCoast || stopRampFirst);
    endproperty
    property p_latchHold;
        (!faultResetIn && !ctlWr) [*6] ##0 faultContactOut |=> faultContactOut;
    endproperty
    property p_methodHold;
        !pwrWr [*3] |=> $stable(activeMethod);
    endproperty
    property p_curveHold;
        !thWr [*2] |=> $stable(motorCurveConstTorque);
    endproperty
    property p_driveTrip;
        hiCnt >= DRIVE_TRIP_CYC + 4 |-> driveThermalTrip;
    endproperty
    property p_driveHold;
        (!faultResetIn && !ctlWr) [*6] ##0 driveThermalTrip |=> driveThermalTrip;
    endproperty
    property p_slvErr;
        acc |-> pslverr == !mapped;
    endproperty
    property p_rdUnmapped;
        acc && !pwrite && !mapped |-> prdata == 32'h0000_0000;
    endproperty

    a_faultCode: assert property (p_faultCode) else $error("fault code wrong");
    a_stopAction: assert property (p_stopAction) else $error("stop outputs wrong");
    a_latchHold: assert property (p_latchHold) else $error("fault latch lost");
    a_methodHold: assert property (p_methodHold) else $error("method changed");
    a_curveHold: assert property (p_curveHold) else $error("curve changed");
    a_driveTrip: assert property (p_driveTrip) else $error("drive trip late");
    a_driveHold: assert property (p_driveHold) else $error("drive trip lost");
    a_slvErr: assert property (p_slvErr) else $error("pslverr wrong");
    a_rdUnmapped: assert property (p_rdUnmapped) else $error("unmapped read not zero");

    c_fault: cover property ($rose(faultContactOut));
    c_drive: cover property ($rose(driveThermalTrip));
    c_power: cover property (pwrWr);
    c_unmapped: cover property (acc && !mapped);
endmodule

// ### verification/drive_side_model.sv
// Behavioural model of the fault contact, run and reset wiring
module drive_side_model (
    // Clock
    input  wire logic clk_sys,
    // Bench commands
    input  wire logic faultOn,
    input  wire logic ncContact,
    input  wire logic runOn,
    input  wire logic revSel,
    input  wire logic resetOn,
    // Pins toward the drive
    output logic      extFaultContact,
    output logic      forwardRunInput,
    output logic      reverseRunInput,
    output logic      faultResetIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Run stays held whatever the supply does; only the bench drops it
    always @(posedge clk_sys) begin
        extFaultContact <= faultOn ^ ncContact;
        forwardRunInput <= runOn & ~revSel;
        reverseRunInput <= runOn & revSel;
        faultResetIn <= resetOn;
    end
endmodule
